// ==== hdl/tdc_cmd_interp.sv ====
// Command interpreter configuring the time-to-digital converter chips.
`timescale 1ns/1ns
`include "tdc_cmd_map.svh"

// What this block does
// - After read-resolution opcode, hold waiting until host reads one word.
// - Edge modes report resolution bits 1:0 as 800, 200 or 100 ps.
// - Pair mode reports leading resolution code in bits 2:0.
// - Pair mode reports pulse width resolution code in bits 11:8.
// - Set dead time opcode waits for one word; bits 1:0 kept.
// - Read dead time opcode returns bits 1:0, waiting for the read.
// - Header/trailer enable and disable opcodes, no parameter word.
// - Header/trailer status read returns enable flag in bit 0.
// - Maximum hits opcode waits for one word; bits 3:0 hit limit.
// - Too many hits append error word 0x1000 before trailer.
// - Read maximum hits returns the limit code in bits 3:0.
// - Error mark enable (default) and disable opcodes.
// - Bypass-on-error enable and disable opcodes.
// - Error type enable opcode waits for one word; eleven mask bits.
// - Mask bits 0..10 map to the eleven internal error types.
// - Read error type opcode returns the eleven mask bits.
// - Buffer size opcode waits for one word; bits 2:0 depth code.
// - Edge setting selects pair, trailing, leading or both.
module tdc_cmd_interp (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic             irq_o,
    output logic             busy_o,
    output logic             hdr_trl_en_o,
    output logic             err_mark_en_o,
    output logic             err_bypass_en_o,
    output logic      [1:0]  dead_time_o,
    output logic      [3:0]  max_hits_o,
    output logic      [10:0] err_type_en_o,
    output logic      [2:0]  level_one_hit_buffer_size_o,
    output logic      [1:0]  edge_mode_o,
    input  wire logic        hit_i,
    input  wire logic        event_end_i,
    output logic             size_err_o,
    output logic      [15:0] size_err_word_o
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration state and command sequencer.

    tdc_cmd_pkg::cmd_state_type state_reg, state_next;
    logic [7:0]  op_reg, op_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        hdr_reg, hdr_next;
    logic        mark_reg, mark_next;
    logic        byp_reg, byp_next;
    logic [1:0]  dead_reg, dead_next;
    logic [3:0]  maxhit_reg, maxhit_next;
    logic [10:0] errmask_reg, errmask_next;
    logic [2:0]  bufsize_reg, bufsize_next;
    logic [1:0]  edge_reg, edge_next;
    logic [1:0]  res_lt_reg, res_lt_next;
    logic [2:0]  res_pair_reg, res_pair_next;
    logic [3:0]  res_width_reg, res_width_next;
    logic [3:0]  irq_stat_reg, irq_stat_next;
    logic [3:0]  irq_mask_reg, irq_mask_next;
    logic        irq_reg, irq_next;
    logic [3:0]  ev_set;

    logic        cmd_wr;
    logic        cmd_rd;
    logic [15:0] read_word;
    logic        size_pulse;

    assign cmd_wr = wr_i && (addr_i == `CMD_PORT_ADDR);
    assign cmd_rd = rd_i && (addr_i == `CMD_PORT_ADDR);

    // Word the pending read command returns, built from live settings.
    always_comb begin
        read_word = 16'h0000;
        case (op_reg)
            `OP_READ_RES: begin
                if (edge_reg == tdc_cmd_pkg::EDGE_PAIR) begin
                    read_word[2:0]  = res_pair_reg;
                    read_word[11:8] = res_width_reg;
                end else begin
                    // Outside pair mode only the two low bits carry a code.
                    read_word[1:0] = res_lt_reg;
                end
            end
            `OP_READ_DEAD:    read_word[1:0]  = dead_reg;
            `OP_READ_HDR:     read_word[0]    = hdr_reg;
            `OP_READ_MAXHIT:  read_word[3:0]  = maxhit_reg;
            `OP_READ_ERRMASK: read_word[10:0] = errmask_reg;
            default:          read_word = 16'h0000;
        endcase
    end

    always_comb begin
        state_next     = state_reg;
        op_next        = op_reg;
        // Read data stand for one cycle only and are zero otherwise.
        rdata_next     = 16'h0000;
        hdr_next       = hdr_reg;
        mark_next      = mark_reg;
        byp_next       = byp_reg;
        dead_next      = dead_reg;
        maxhit_next    = maxhit_reg;
        errmask_next   = errmask_reg;
        bufsize_next   = bufsize_reg;
        edge_next      = edge_reg;
        res_lt_next    = res_lt_reg;
        res_pair_next  = res_pair_reg;
        res_width_next = res_width_reg;
        irq_mask_next  = irq_mask_reg;
        ev_set         = 4'h0;
        case (state_reg)
            tdc_cmd_pkg::ST_IDLE: begin
                if (cmd_wr) begin
                    op_next = wdata_i[15:8];
                    case (wdata_i[15:8])
                        `OP_HDR_ON: begin
                            hdr_next = 1'b1;
                            ev_set[`IRQ_CMD_DONE] = 1'b1;
                        end
                        `OP_HDR_OFF: begin
                            hdr_next = 1'b0;
                            ev_set[`IRQ_CMD_DONE] = 1'b1;
                        end
                        `OP_MARK_ON: begin
                            mark_next = 1'b1;
                            ev_set[`IRQ_CMD_DONE] = 1'b1;
                        end
                        `OP_MARK_OFF: begin
                            mark_next = 1'b0;
                            ev_set[`IRQ_CMD_DONE] = 1'b1;
                        end
                        `OP_BYP_ON: begin
                            byp_next = 1'b1;
                            ev_set[`IRQ_CMD_DONE] = 1'b1;
                        end
                        `OP_BYP_OFF: begin
                            byp_next = 1'b0;
                            ev_set[`IRQ_CMD_DONE] = 1'b1;
                        end
                        `OP_SET_DEAD, `OP_SET_MAXHIT, `OP_SET_ERRMASK,
                        `OP_SET_BUFSIZE: begin
                            state_next = tdc_cmd_pkg::ST_WWAIT;
                        end
                        `OP_READ_RES, `OP_READ_DEAD, `OP_READ_HDR,
                        `OP_READ_MAXHIT, `OP_READ_ERRMASK: begin
                            state_next = tdc_cmd_pkg::ST_RWAIT;
                        end
                        // An unknown opcode is flagged and dropped; the
                        // sequencer stays idle, so the next word is again
                        // taken as an opcode.
                        default: ev_set[`IRQ_BAD_OP] = 1'b1;
                    endcase
                end else if (cmd_rd) begin
                    // A read with no command pending returns zero.
                    ev_set[`IRQ_OVERRUN] = 1'b1;
                end
            end
            tdc_cmd_pkg::ST_WWAIT: begin
                if (cmd_wr) begin
                    state_next = tdc_cmd_pkg::ST_IDLE;
                    ev_set[`IRQ_CMD_DONE] = 1'b1;
                    // Only the low bits that each setting uses are kept;
                    // the rest of the parameter word is ignored.
                    case (op_reg)
                        `OP_SET_DEAD:    dead_next = wdata_i[1:0];
                        `OP_SET_MAXHIT:  maxhit_next = wdata_i[3:0];
                        `OP_SET_ERRMASK: errmask_next = wdata_i[10:0];
                        `OP_SET_BUFSIZE: bufsize_next = wdata_i[2:0];
                        default:         state_next = tdc_cmd_pkg::ST_IDLE;
                    endcase
                end else if (cmd_rd) begin
                    ev_set[`IRQ_OVERRUN] = 1'b1;
                end
            end
            tdc_cmd_pkg::ST_RWAIT: begin
                if (cmd_rd) begin
                    rdata_next = read_word;
                    state_next = tdc_cmd_pkg::ST_IDLE;
                    ev_set[`IRQ_CMD_DONE] = 1'b1;
                end else if (cmd_wr) begin
                    // Writes are refused until the pending word is read.
                    ev_set[`IRQ_OVERRUN] = 1'b1;
                end
            end
            default: state_next = tdc_cmd_pkg::ST_IDLE;
        endcase
        // Side registers outside the command port. They may be written in
        // any state, so the mask or edge setting can change without
        // upsetting a pending command.
        if (wr_i) begin
            case (addr_i)
                `IRQ_MASK_ADDR:  irq_mask_next = wdata_i[3:0];
                `EDGE_MODE_ADDR: edge_next = wdata_i[1:0];
                `RES_CFG_ADDR: begin
                    res_lt_next    = wdata_i[1:0];
                    res_pair_next  = wdata_i[6:4];
                    res_width_next = wdata_i[11:8];
                end
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                `CMD_PORT_ADDR: if (state_reg == tdc_cmd_pkg::ST_RWAIT)
                    rdata_next = read_word;
                // The state shows here, so software can spot a stuck wait.
                `STATUS_ADDR:
                    rdata_next = {13'h0000, size_err_o, state_reg};
                `IRQ_STATUS_ADDR: rdata_next = {12'h000, irq_stat_reg};
                `IRQ_MASK_ADDR:   rdata_next = {12'h000, irq_mask_reg};
                `EDGE_MODE_ADDR:  rdata_next = {14'h0000, edge_reg};
                `RES_CFG_ADDR:    rdata_next = {4'h0, res_width_reg,
                                                1'b0, res_pair_reg,
                                                2'h0, res_lt_reg};
                default:          rdata_next = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hit limit check; a new event starts after each event end.

    logic [8:0] hits_reg, hits_next;
    logic [8:0] limit;
    logic       over_reg, over_next;
    logic       serr_reg, serr_next;

    // The default covers no limit and the meaningless codes; the compare
    // below is gated off for all of them.
    always_comb begin
        case (maxhit_reg)
            4'h0:    limit = 9'h000;
            4'h1:    limit = 9'h001;
            4'h2:    limit = 9'h002;
            4'h3:    limit = 9'h004;
            4'h4:    limit = 9'h008;
            4'h5:    limit = 9'h010;
            4'h6:    limit = 9'h020;
            4'h7:    limit = 9'h040;
            4'h8:    limit = 9'h080;
            default: limit = 9'h1ff;
        endcase
    end

    always_comb begin
        hits_next  = hits_reg;
        over_next  = over_reg;
        serr_next  = 1'b0;
        // The count stops at its top, so a long burst cannot wrap round
        // and slip back under the limit.
        if (hit_i && (hits_reg != 9'h1ff)) begin
            hits_next = hits_reg + 9'h001;
        end
        // Codes above the no-limit code are meaningless and never trip.
        if (hit_i && (maxhit_reg < `MAXHIT_LAST) && (hits_reg >= limit)) begin
            over_next = 1'b1;
        end
        if (event_end_i) begin
            serr_next = over_next;
            hits_next = 9'h000;
            over_next = 1'b0;
        end
    end
    assign size_pulse = serr_next;

    ////////////////////////////////////////////////////////////////////////
    // Busy flag and error word, each in flip-flops of its own.

    logic        busy_reg, busy_next;
    logic [15:0] serr_word_reg, serr_word_next;

    // Both come from next-state values, so the pins never glitch with a
    // decode; the host sees the same timing as from the state register.
    // Sixteen flip-flops for the word buy a clean bus to the chips.
    always_comb begin
        busy_next      = (state_next != tdc_cmd_pkg::ST_IDLE);
        serr_word_next = 16'h0000;
        if (serr_next) begin
            serr_word_next = `SIZE_ERR_FLAG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: a set arriving with the clearing read wins.
    // The output is registered from the next status and mask, so it lines
    // up with the status register.

    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (rd_i && (addr_i == `IRQ_STATUS_ADDR)) begin
            irq_stat_next = 4'h0;
        end
        irq_stat_next = irq_stat_next | ev_set
                        | {size_pulse, 3'b000};
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg     <= tdc_cmd_pkg::ST_IDLE;
            op_reg        <= 8'h00;
            rdata_reg     <= 16'h0000;
            hdr_reg       <= `HDR_RST;
            mark_reg      <= `MARK_RST;
            byp_reg       <= `BYP_RST;
            dead_reg      <= `DEAD_RST;
            maxhit_reg    <= `MAXHIT_RST;
            errmask_reg   <= `ERRMASK_RST;
            bufsize_reg   <= `BUFSIZE_RST;
            edge_reg      <= `EDGE_RST;
            res_lt_reg    <= `RES_LT_RST;
            res_pair_reg  <= `RES_PAIR_RST;
            res_width_reg <= `RES_WIDTH_RST;
            irq_stat_reg  <= 4'h0;
            irq_mask_reg  <= 4'h0;
            irq_reg       <= 1'b0;
            hits_reg      <= 9'h000;
            over_reg      <= 1'b0;
            serr_reg      <= 1'b0;
            busy_reg      <= 1'b0;
            serr_word_reg <= 16'h0000;
        end else begin
            state_reg     <= state_next;
            op_reg        <= op_next;
            rdata_reg     <= rdata_next;
            hdr_reg       <= hdr_next;
            mark_reg      <= mark_next;
            byp_reg       <= byp_next;
            dead_reg      <= dead_next;
            maxhit_reg    <= maxhit_next;
            errmask_reg   <= errmask_next;
            bufsize_reg   <= bufsize_next;
            edge_reg      <= edge_next;
            res_lt_reg    <= res_lt_next;
            res_pair_reg  <= res_pair_next;
            res_width_reg <= res_width_next;
            irq_stat_reg  <= irq_stat_next;
            irq_mask_reg  <= irq_mask_next;
            irq_reg       <= irq_next;
            hits_reg      <= hits_next;
            over_reg      <= over_next;
            serr_reg      <= serr_next;
            busy_reg      <= busy_next;
            serr_word_reg <= serr_word_next;
        end
    end

    // The chips see the settings directly; bit order of the mask is the
    // vernier, coarse, channel select, buffer, trigger fifo, trigger state,
    // readout fifo, readout state, setup, control and scan errors.
    assign rdata_o                     = rdata_reg;
    assign irq_o                       = irq_reg;
    assign busy_o                      = busy_reg;
    assign hdr_trl_en_o                = hdr_reg;
    assign err_mark_en_o               = mark_reg;
    assign err_bypass_en_o             = byp_reg;
    assign dead_time_o                 = dead_reg;
    assign max_hits_o                  = maxhit_reg;
    assign err_type_en_o               = errmask_reg;
    assign level_one_hit_buffer_size_o = bufsize_reg;
    assign edge_mode_o                 = edge_reg;
    assign size_err_o                  = serr_reg;
    assign size_err_word_o             = serr_word_reg;

endmodule // tdc_cmd_interp

// ==== hdl/tdc_cmd_map.svh ====
// Offsets, opcodes, field positions and reset values of the command interpreter.
`ifndef TDC_CMD_MAP_SVH
`define TDC_CMD_MAP_SVH

// Register offsets on the plain register port.
`define CMD_PORT_ADDR     4'h0
`define STATUS_ADDR       4'h1
`define IRQ_STATUS_ADDR   4'h2
`define IRQ_MASK_ADDR     4'h3
`define EDGE_MODE_ADDR    4'h4
`define RES_CFG_ADDR      4'h5

// Opcodes, taken from the upper byte of a command word.
`define OP_READ_RES       8'h26
`define OP_SET_DEAD       8'h28
`define OP_READ_DEAD      8'h29
`define OP_HDR_ON         8'h30
`define OP_HDR_OFF        8'h31
`define OP_READ_HDR       8'h32
`define OP_SET_MAXHIT     8'h33
`define OP_READ_MAXHIT    8'h34
`define OP_MARK_ON        8'h35
`define OP_MARK_OFF       8'h36
`define OP_BYP_ON         8'h37
`define OP_BYP_OFF        8'h38
`define OP_SET_ERRMASK    8'h39
`define OP_READ_ERRMASK   8'h3a
`define OP_SET_BUFSIZE    8'h3b

// Reset values of the configuration, and the last (no-limit) hit limit code.
`define DEAD_RST          2'h0
`define MAXHIT_RST        4'h9
`define MAXHIT_LAST       4'h9
`define BUFSIZE_RST       3'h7
`define ERRMASK_RST       11'h000
`define EDGE_RST          2'h2
`define RES_LT_RST        2'h2
`define RES_PAIR_RST      3'h0
`define RES_WIDTH_RST     4'h0
`define HDR_RST           1'b0
`define MARK_RST          1'b1
`define BYP_RST           1'b0

// Error word flag for an event that exceeded its hit limit.
`define SIZE_ERR_FLAG     16'h1000

// Interrupt status bit positions.
`define IRQ_CMD_DONE      0
`define IRQ_BAD_OP        1
`define IRQ_OVERRUN       2
`define IRQ_SIZE_ERR      3

`endif

// ==== hdl/tdc_cmd_pkg.sv ====
// Types shared by the command interpreter.
package tdc_cmd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WWAIT = 2'b01,
        ST_RWAIT = 2'b10
    } cmd_state_type;

    typedef enum logic [1:0] {
        EDGE_PAIR     = 2'b00,
        EDGE_TRAILING = 2'b01,
        EDGE_LEADING  = 2'b10,
        EDGE_BOTH     = 2'b11
    } edge_mode_type;
endpackage

// ==== dv/tdc_cmd_interp_assertions.sv ====
// Concurrent checks on the command interpreter ports.
`timescale 1ns/1ns
`include "tdc_cmd_map.svh"
module tdc_cmd_interp_assertions (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        busy_o,
    input wire logic        hdr_trl_en_o,
    input wire logic [1:0]  dead_time_o,
    input wire logic [3:0]  max_hits_o,
    input wire logic        event_end_i,
    input wire logic        size_err_o,
    input wire logic [15:0] size_err_word_o
);
    // Remembers which opcode opened the current wait.
    logic [7:0] last_op_reg;
    logic [7:0] last_op_next;
    always_comb begin
        last_op_next = last_op_reg;
        if (wr_i && addr_i == `CMD_PORT_ADDR && !busy_o)
            last_op_next = wdata_i[15:8];
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i)
            last_op_reg <= 8'h00;
        else
            last_op_reg <= last_op_next;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence op_s(op);
        wr_i && addr_i == `CMD_PORT_ADDR && !busy_o && wdata_i[15:8] == op;
    endsequence
    sequence par_wr_s(op);
        wr_i && addr_i == `CMD_PORT_ADDR && busy_o && last_op_reg == op;
    endsequence
    sequence res_rd_s(op);
        rd_i && addr_i == `CMD_PORT_ADDR && busy_o && last_op_reg == op;
    endsequence
    wait_start_a: assert property (op_s(`OP_READ_RES) |=> busy_o)
        else $error("no wait after read opcode");
    wait_hold_a: assert property (busy_o && !((wr_i || rd_i) &&
        addr_i == `CMD_PORT_ADDR) |=> busy_o) else $error("wait left");
    dead_set_a: assert property (par_wr_s(`OP_SET_DEAD) |=>
        !busy_o && dead_time_o == $past(wdata_i[1:0]))
        else $error("dead time not taken");
    dead_read_a: assert property (res_rd_s(`OP_READ_DEAD) |=>
        !busy_o && rdata_o[1:0] == dead_time_o) else $error("dead read");
    hdr_on_a: assert property (op_s(`OP_HDR_ON) |=>
        hdr_trl_en_o && !busy_o) else $error("header enable");
    hdr_off_a: assert property (op_s(`OP_HDR_OFF) |=>
        !hdr_trl_en_o && !busy_o) else $error("header disable");
    hdr_read_a: assert property (res_rd_s(`OP_READ_HDR) |=>
        rdata_o[0] == hdr_trl_en_o) else $error("header status read");
    max_set_a: assert property (par_wr_s(`OP_SET_MAXHIT) |=>
        max_hits_o == $past(wdata_i[3:0])) else $error("hit limit set");
    max_read_a: assert property (res_rd_s(`OP_READ_MAXHIT) |=>
        rdata_o[3:0] == max_hits_o) else $error("hit limit read");
    size_word_a: assert property (size_err_o |-> $past(event_end_i) &&
        size_err_word_o == `SIZE_ERR_FLAG) else $error("size error word");
    word_idle_a: assert property (!size_err_o |->
        size_err_word_o == 16'h0000) else $error("stray error word");
endmodule // tdc_cmd_interp_assertions

bind tdc_cmd_interp tdc_cmd_interp_assertions watch (
    .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .busy_o,
    .hdr_trl_en_o, .dead_time_o, .max_hits_o, .event_end_i, .size_err_o,
    .size_err_word_o
);

// ==== dv/tdc_host_model.sv ====
// Host bus master model driving the command port.
`timescale 1ns/1ns
module tdc_host_model (
    input  wire logic        mclk_i,
    input  wire logic [15:0] rdata_i,
    output logic      [3:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    // Extra idle cycles after each access, to play a slow host.
    int slow = 0;
    initial begin
        addr_o = 4'h0;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released lines are inverted so a stale value cannot look valid.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        repeat (slow + 1) @(posedge mclk_i);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(negedge mclk_i);
        d = rdata_i;
        repeat (slow + 1) @(posedge mclk_i);
    endtask
    task automatic cmd_wr(input logic [7:0] op, input logic [15:0] d);
        wr(4'h0, {op, 8'ha5});
        wr(4'h0, d);
    endtask
    task automatic cmd_rd(input logic [7:0] op, output logic [15:0] d);
        wr(4'h0, {op, 8'h5a});
        rd(4'h0, d);
    endtask
endmodule // tdc_host_model

// ==== dv/tdc_readout_config_commands_tb.sv ====
// Self-checking bench for the command interpreter.
`timescale 1ns/1ns
`include "tdc_cmd_map.svh"
module tdc_readout_config_commands_tb;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hit = 1'b0;
    logic        ev_end = 1'b0;
    logic [3:0]  addr, max_hits;
    logic [15:0] wdata, rdata, err_word, r;
    logic        wr, rd, irq, busy, hdr, mark, byp, size_err;
    logic [1:0]  dead, edge_m;
    logic [10:0] err_en;
    logic [2:0]  buf_sz;
    int          n_mismatch = 0;
    int          n_compared = 0;
    always #4 mclk_i = ~mclk_i;
    tdc_cmd_interp dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .irq_o(irq), .busy_o(busy), .hdr_trl_en_o(hdr),
        .err_mark_en_o(mark), .err_bypass_en_o(byp), .dead_time_o(dead),
        .max_hits_o(max_hits), .err_type_en_o(err_en),
        .level_one_hit_buffer_size_o(buf_sz), .edge_mode_o(edge_m),
        .hit_i(hit), .event_end_i(ev_end), .size_err_o(size_err),
        .size_err_word_o(err_word));
    tdc_host_model host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic t_params;
        for (int i = 0; i < 4; i++) begin
            host.cmd_wr(`OP_SET_DEAD, 16'hfffc | 16'(i));
            chk(16'(dead), 16'(i));
            host.cmd_rd(`OP_READ_DEAD, r);
            chk(r & 16'h0003, 16'(i));
        end
        for (int i = 0; i < 10; i++) begin
            host.cmd_wr(`OP_SET_MAXHIT, 16'hfff0 | 16'(i));
            chk(16'(max_hits), 16'(i));
            host.cmd_rd(`OP_READ_MAXHIT, r);
            chk(r & 16'h000f, 16'(i));
        end
        for (int i = 0; i < 8; i++) begin
            host.cmd_wr(`OP_SET_BUFSIZE, 16'(i));
            chk(16'(buf_sz), 16'(i));
        end
        for (int i = 0; i < 2; i++) begin
            host.cmd_wr(`OP_SET_ERRMASK, i ? 16'h02a5 : 16'hfd5a);
            chk(16'(err_en), i ? 16'h02a5 : 16'h055a);
            host.cmd_rd(`OP_READ_ERRMASK, r);
            chk(r & 16'h07ff, i ? 16'h02a5 : 16'h055a);
        end
    endtask
    task automatic t_toggles;
        logic [7:0] ops [6] = '{`OP_HDR_ON, `OP_MARK_OFF, `OP_BYP_ON,
                                `OP_HDR_OFF, `OP_MARK_ON, `OP_BYP_OFF};
        logic [3:0] exp [6] = '{4'hc, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};
        for (int i = 0; i < 6; i++) begin
            host.wr(4'h0, {ops[i], 8'hff});
            chk(16'({hdr, mark, byp, busy}), 16'(exp[i]));
            host.cmd_rd(`OP_READ_HDR, r);
            chk(r & 16'h0001, 16'(exp[i][3]));
        end
    endtask
    task automatic t_res;
        host.cmd_rd(`OP_READ_RES, r);
        chk(r & 16'h0003, 16'h0002);
        host.wr(`RES_CFG_ADDR, 16'h0d51);
        for (int i = 3; i >= 0; i--) begin
            host.wr(`EDGE_MODE_ADDR, 16'(i));
            chk(16'(edge_m), 16'(i));
            host.cmd_rd(`OP_READ_RES, r);
            if (i != 0) begin
                chk(r & 16'h0003, 16'h0001);
            end else begin
                chk(r & 16'h0f07, 16'h0d05);
            end
        end
    endtask
    task automatic t_wait;
        host.slow = 3;
        host.wr(4'h0, {`OP_SET_DEAD, 8'h00});
        host.rd(4'h0, r);
        chk(r, 16'h0000);
        chk(16'({busy, dead}), 16'h0007);
        host.wr(4'h0, 16'h0002);
        chk(16'({busy, dead}), 16'h0002);
        host.wr(4'h0, {`OP_READ_ERRMASK, 8'h00});
        host.wr(4'h0, 16'h3000);
        chk(16'({busy, hdr}), 16'h0002);
        host.rd(4'h0, r);
        chk(16'({busy, r[10:0]}), 16'h02a5);
        host.slow = 0;
    endtask
    task automatic t_irq;
        host.rd(`IRQ_STATUS_ADDR, r);
        host.wr(`IRQ_MASK_ADDR, 16'h0002);
        host.wr(4'h0, 16'h3000);
        chk(16'(irq), 16'h0000);
        host.wr(4'h0, 16'h7f00);
        chk(16'(irq), 16'h0001);
        host.rd(`IRQ_STATUS_ADDR, r);
        chk(r & 16'h0002, 16'h0002);
        chk(16'(irq), 16'h0000);
        host.rd(4'hf, r);
        chk(r, 16'h0000);
    endtask
    task automatic ev(input int n, input logic e);
        hit <= 1'b1;
        repeat (n) @(posedge mclk_i);
        hit <= 1'b0;
        ev_end <= 1'b1;
        @(posedge mclk_i);
        ev_end <= 1'b0;
        @(negedge mclk_i);
        chk(16'(size_err), 16'(e));
        chk(err_word, e ? `SIZE_ERR_FLAG : 16'h0000);
        @(posedge mclk_i);
    endtask
    task automatic t_size;
        host.cmd_wr(`OP_SET_MAXHIT, 16'h0002);
        ev(2, 1'b0);
        ev(3, 1'b1);
        host.cmd_wr(`OP_SET_MAXHIT, 16'h0000);
        ev(1, 1'b1);
        host.cmd_wr(`OP_SET_MAXHIT, 16'h0008);
        ev(128, 1'b0);
        ev(129, 1'b1);
        host.cmd_wr(`OP_SET_MAXHIT, 16'h0009);
        ev(300, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        chk(16'({hdr, mark, byp, busy, dead}), 16'h0010);
        chk(16'({max_hits, buf_sz, edge_m}), 16'h013e);
        t_params;
        t_toggles;
        t_res;
        t_wait;
        t_irq;
        t_size;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        close_out;
    end
endmodule // tdc_readout_config_commands_tb
